// ==== common/decode_if.sv ====
interface decode_if;
  logic is_irq;
  logic remap;
  logic sub_valid;
  logic rsvd_bad;
  logic [15:0] handle;
  logic [15:0] sub_index;

  modport producer(output is_irq, remap, sub_valid, rsvd_bad, handle, sub_index);
  modport consumer(input is_irq, remap, sub_valid, rsvd_bad, handle, sub_index);
endinterface : decode_if

// ==== common/irq_decode_pkg.sv ====
package irq_decode_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int ID_W = 16;
  localparam int CNT_W = 16;
  localparam int REASON_W = 8;
  localparam int BUS_W = 8;

  // Interrupt address window and request field layout
  localparam logic [11:0] IRQ_ID = 12'hFEE;
  localparam int ID_MSB = 31;
  localparam int ID_LSB = 20;
  localparam int HLO_MSB = 19;
  localparam int HLO_LSB = 5;
  localparam int FMT_BIT = 4;
  localparam int SHV_BIT = 3;
  localparam int HMSB_BIT = 2;
  localparam int RSVD_MSB = 31;
  localparam int RSVD_LSB = 16;
  localparam int SUB_MSB = 15;
  localparam logic [3:0] DWORD_BE = 4'hF;

  localparam logic [REASON_W-1:0] FAULT_RSVD = 8'h20;

  // Register map, byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] BRIDGE_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] FAULT_OFS = 8'h0C;

  localparam int CTRL_EN_BIT = 0;
  localparam int BRIDGE_EN_BIT = 8;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic BRIDGE_EN_RESET = 1'b0;
  localparam logic [BUS_W-1:0] BRIDGE_BUS_RESET = 8'h00;

  function automatic logic [ID_W-1:0] handle_of(input logic [DATA_W-1:0] addr);
    handle_of = {addr[HMSB_BIT], addr[HLO_MSB:HLO_LSB]};
  endfunction : handle_of

endpackage : irq_decode_pkg

// ==== rtl/interrupt_request_decoder.sv ====
// Contract
// - Only DWORD writes with address bits 31:20 equal FEEh are interrupt requests.
// - Interrupts raised by the remapping unit itself bypass this decoder.
// - Address bit 4 clear means compatibility format, set means remappable.
// - Handle is address bit 2 above address bits 19:5, sixteen bits.
// - Address bit 3 is the sub-index valid flag.
// - Address bits 1:0 of remappable requests influence nothing.
// - With sub-index valid, data bits 31:16 must be zero; otherwise ignored.
// - With sub-index valid, data bits 15:0 are the sub-index; otherwise ignored.
// - The requester identifier from the transaction header is the source identifier.
// - Bridge-forwarded requests may carry secondary bus, device-function zero; not isolated.
// - Nonzero reserved fields block the request with fault reason 20h.
// - Reserved check precedes field extraction; failing requests are blocked.
module interrupt_request_decoder (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [irq_decode_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [irq_decode_pkg::DATA_W-1:0] wb_dat_i,
  output logic [irq_decode_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [3:0] req_be_i,
  input wire logic req_internal_i,
  input wire logic [irq_decode_pkg::DATA_W-1:0] req_addr_i,
  input wire logic [irq_decode_pkg::DATA_W-1:0] req_data_i,
  input wire logic [irq_decode_pkg::ID_W-1:0] req_requester_ident_i,
  output logic dec_valid_o,
  output logic dec_remap_o,
  output logic [irq_decode_pkg::ID_W-1:0] dec_handle_o,
  output logic dec_sub_index_valid_o,
  output logic [irq_decode_pkg::ID_W-1:0] dec_sub_index_o,
  output logic [irq_decode_pkg::ID_W-1:0] dec_requester_ident_o,
  output logic dec_aliased_o,
  output logic [irq_decode_pkg::DATA_W-1:0] dec_addr_o,
  output logic [irq_decode_pkg::DATA_W-1:0] dec_data_o,
  output logic fault_valid_o,
  output logic [irq_decode_pkg::REASON_W-1:0] fault_reason_o,
  output logic [irq_decode_pkg::ID_W-1:0] fault_requester_ident_o
);
  import irq_decode_pkg::*;

  decode_if fld ();

  logic ctrl_en_reg;
  logic bridge_en_reg;
  logic [BUS_W-1:0] bridge_bus_reg;
  logic [CNT_W-1:0] accept_cnt_reg;
  logic [CNT_W-1:0] fault_cnt_reg;
  logic [REASON_W-1:0] last_reason_reg;
  logic [ID_W-1:0] last_requester_reg;
  logic [DATA_W-1:0] dat_reg;
  logic ack_reg;
  logic dec_valid_reg;
  logic dec_remap_reg;
  logic [ID_W-1:0] dec_handle_reg;
  logic dec_sub_valid_reg;
  logic [ID_W-1:0] dec_sub_index_reg;
  logic [ID_W-1:0] dec_requester_reg;
  logic dec_aliased_reg;
  logic [DATA_W-1:0] dec_addr_reg;
  logic [DATA_W-1:0] dec_data_reg;
  logic fault_valid_reg;
  logic [REASON_W-1:0] fault_reason_reg;
  logic [ID_W-1:0] fault_requester_reg;

  request_field_splitter u_splitter (
    .addr_i(req_addr_i),
    .data_i(req_data_i),
    .remap_en_i(ctrl_en_reg),
    .fields(fld.producer)
  );

  // Request classification
  wire dword_write = req_valid_i && req_write_i && (req_be_i == DWORD_BE);
  wire take = dword_write && !req_internal_i && fld.is_irq;
  wire blocked = take && fld.rsvd_bad;
  wire accepted = take && !blocked;
  // Bridge alias: secondary bus with device and function zero
  wire aliased = bridge_en_reg && (req_requester_ident_i[15:8] == bridge_bus_reg)
                 && (req_requester_ident_i[7:0] == 8'h00);

  // Register bus decode
  wire bus_hit = wb_cyc_i && wb_stb_i && !ack_reg;
  wire bus_wr = bus_hit && wb_we_i;
  wire sel_ctrl = (wb_adr_i == CTRL_OFS);
  wire sel_bridge = (wb_adr_i == BRIDGE_OFS);
  wire sel_status = (wb_adr_i == STATUS_OFS);
  wire sel_fault = (wb_adr_i == FAULT_OFS);
  wire wr_ctrl = bus_wr && sel_ctrl && wb_sel_i[0];
  wire wr_bus = bus_wr && sel_bridge && wb_sel_i[0];
  wire wr_bridge_en = bus_wr && sel_bridge && wb_sel_i[1];
  wire clr_status = bus_wr && sel_status;

  wire [DATA_W-1:0] rd_ctrl = {31'h00000000, ctrl_en_reg};
  wire [DATA_W-1:0] rd_bridge = {23'h000000, bridge_en_reg, bridge_bus_reg};
  wire [DATA_W-1:0] rd_status = {fault_cnt_reg, accept_cnt_reg};
  wire [DATA_W-1:0] rd_fault = {last_requester_reg, 8'h00, last_reason_reg};
  wire [DATA_W-1:0] rd_mux = sel_ctrl ? rd_ctrl :
                             sel_bridge ? rd_bridge :
                             sel_status ? rd_status :
                             sel_fault ? rd_fault : 32'h00000000;

  // Clearing the counters loses no event arriving in the same cycle
  wire [CNT_W-1:0] accept_base = clr_status ? 16'h0000 : accept_cnt_reg;
  wire [CNT_W-1:0] fault_base = clr_status ? 16'h0000 : fault_cnt_reg;
  wire [CNT_W-1:0] accept_cnt_next = accept_base + {15'h0000, accepted};
  wire [CNT_W-1:0] fault_cnt_next = fault_base + {15'h0000, blocked};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en_reg <= CTRL_EN_RESET;
      bridge_en_reg <= BRIDGE_EN_RESET;
      bridge_bus_reg <= BRIDGE_BUS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_reg <= wb_dat_i[CTRL_EN_BIT];
      end
      if (wr_bus) begin
        bridge_bus_reg <= wb_dat_i[BUS_W-1:0];
      end
      if (wr_bridge_en) begin
        bridge_en_reg <= wb_dat_i[BRIDGE_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_hit;
      if (bus_hit) begin
        dat_reg <= wb_we_i ? 32'h00000000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accept_cnt_reg <= 16'h0000;
      fault_cnt_reg <= 16'h0000;
      last_reason_reg <= 8'h00;
      last_requester_reg <= 16'h0000;
    end else begin
      accept_cnt_reg <= accept_cnt_next;
      fault_cnt_reg <= fault_cnt_next;
      if (blocked) begin
        last_reason_reg <= FAULT_RSVD;
        last_requester_reg <= req_requester_ident_i;
      end
    end
  end

  // Decoded request toward the table lookup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_reg <= 1'b0;
      dec_remap_reg <= 1'b0;
      dec_handle_reg <= 16'h0000;
      dec_sub_valid_reg <= 1'b0;
      dec_sub_index_reg <= 16'h0000;
      dec_requester_reg <= 16'h0000;
      dec_aliased_reg <= 1'b0;
      dec_addr_reg <= 32'h00000000;
      dec_data_reg <= 32'h00000000;
    end else begin
      dec_valid_reg <= accepted;
      if (accepted) begin
        dec_remap_reg <= fld.remap;
        dec_handle_reg <= fld.handle;
        dec_sub_valid_reg <= fld.sub_valid;
        dec_sub_index_reg <= fld.sub_index;
        dec_requester_reg <= req_requester_ident_i;
        dec_aliased_reg <= aliased;
        dec_addr_reg <= req_addr_i;
        dec_data_reg <= req_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_valid_reg <= 1'b0;
      fault_reason_reg <= 8'h00;
      fault_requester_reg <= 16'h0000;
    end else begin
      fault_valid_reg <= blocked;
      if (blocked) begin
        fault_reason_reg <= FAULT_RSVD;
        fault_requester_reg <= req_requester_ident_i;
      end
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign dec_valid_o = dec_valid_reg;
  assign dec_remap_o = dec_remap_reg;
  assign dec_handle_o = dec_handle_reg;
  assign dec_sub_index_valid_o = dec_sub_valid_reg;
  assign dec_sub_index_o = dec_sub_index_reg;
  assign dec_requester_ident_o = dec_requester_reg;
  assign dec_aliased_o = dec_aliased_reg;
  assign dec_addr_o = dec_addr_reg;
  assign dec_data_o = dec_data_reg;
  assign fault_valid_o = fault_valid_reg;
  assign fault_reason_o = fault_reason_reg;
  assign fault_requester_ident_o = fault_requester_reg;

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  sequence s_irq_write;
    req_valid_i && req_write_i && (req_be_i == DWORD_BE) && !req_internal_i
      && (req_addr_i[ID_MSB:ID_LSB] == IRQ_ID);
  endsequence

  sequence s_rsvd_bad_remap;
    s_irq_write ##0 (ctrl_en_reg && req_addr_i[FMT_BIT] && req_addr_i[SHV_BIT]
      && (req_data_i[RSVD_MSB:RSVD_LSB] != 16'h0000));
  endsequence

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_outside_window;
    req_valid_i && (req_addr_i[ID_MSB:ID_LSB] != IRQ_ID) |=> !dec_valid_o && !fault_valid_o;
  endproperty
  a_outside_window: assert property (p_outside_window)
    else $error("write outside interrupt window was decoded");

  property p_internal_bypass;
    req_valid_i && req_internal_i |=> !dec_valid_o && !fault_valid_o;
  endproperty
  a_internal_bypass: assert property (p_internal_bypass)
    else $error("internally raised interrupt was decoded");

  property p_format;
    s_irq_write |=> (dec_valid_o || fault_valid_o)
      && (!dec_valid_o || dec_remap_o == ($past(req_addr_i[FMT_BIT]) && $past(ctrl_en_reg)));
  endproperty
  a_format: assert property (p_format)
    else $error("format flag does not follow address bit 4");

  property p_handle;
    dec_valid_o && dec_remap_o |-> dec_handle_o == handle_of($past(req_addr_i));
  endproperty
  a_handle: assert property (p_handle)
    else $error("handle not assembled from address bits 2 and 19:5");

  property p_sub_flag;
    dec_valid_o |-> dec_sub_index_valid_o == (dec_remap_o && $past(req_addr_i[SHV_BIT]));
  endproperty
  a_sub_flag: assert property (p_sub_flag)
    else $error("sub-index valid flag wrong");

  property p_reserved_block;
    s_rsvd_bad_remap |=> fault_valid_o && !dec_valid_o && (fault_reason_o == FAULT_RSVD);
  endproperty
  a_reserved_block: assert property (p_reserved_block)
    else $error("nonzero reserved data not blocked with reason 20h");

  property p_sub_index;
    dec_valid_o |-> dec_sub_index_o
      == (dec_sub_index_valid_o ? $past(req_data_i[SUB_MSB:0]) : 16'h0000);
  endproperty
  a_sub_index: assert property (p_sub_index)
    else $error("sub-index not taken from data bits 15:0");

  property p_requester;
    s_irq_write ##0 !fld.rsvd_bad |=> dec_valid_o
      && (dec_requester_ident_o == $past(req_requester_ident_i));
  endproperty
  a_requester: assert property (p_requester)
    else $error("accepted request missing or wrong requester");

  property p_alias;
    dec_valid_o && dec_aliased_o |-> dec_requester_ident_o[7:0] == 8'h00;
  endproperty
  a_alias: assert property (p_alias)
    else $error("alias flag set for nonzero device-function");

  property p_bus_answer;
    s_bus_req |=> s_ack_pulse;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not acknowledged for exactly one cycle");

endmodule : interrupt_request_decoder

// ==== rtl/request_field_splitter.sv ====
module request_field_splitter (
  input wire logic [irq_decode_pkg::DATA_W-1:0] addr_i,
  input wire logic [irq_decode_pkg::DATA_W-1:0] data_i,
  input wire logic remap_en_i,
  decode_if.producer fields
);
  import irq_decode_pkg::*;

  wire remap_w;
  wire shv_w;

  assign fields.is_irq = (addr_i[ID_MSB:ID_LSB] == IRQ_ID);
  // With remapping off every request is handled as compatibility format
  assign remap_w = remap_en_i && addr_i[FMT_BIT];
  assign shv_w = remap_w && addr_i[SHV_BIT];
  assign fields.remap = remap_w;
  assign fields.sub_valid = shv_w;
  // Bits 1:0 never reach any field or check
  assign fields.handle = remap_w ? handle_of(addr_i) : 16'h0000;
  assign fields.rsvd_bad = shv_w && (data_i[RSVD_MSB:RSVD_LSB] != 16'h0000);
  assign fields.sub_index = shv_w ? data_i[SUB_MSB:0] : 16'h0000;

endmodule : request_field_splitter

// ==== testbench/irq_source_model.sv ====
module irq_source_model (
  input wire logic clk_i,
  output logic valid_o,
  output logic write_o,
  output logic [3:0] be_o,
  output logic internal_o,
  output logic [31:0] addr_o,
  output logic [31:0] data_o,
  output logic [15:0] ident_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    be_o = 4'h0;
    internal_o = 1'b0;
    addr_o = 32'h0;
    data_o = 32'h0;
    ident_o = 16'h0;
  end
  // k is {write, internal, byte enables}; address, data, identifier and byte enables are scrambled once released
  task automatic send(input logic [31:0] a, input logic [31:0] d, input logic [15:0] id,
                      input logic [5:0] k);
    @(posedge clk_i);
    valid_o <= 1'b1;
    {write_o, internal_o, be_o} <= k;
    addr_o <= a;
    data_o <= d;
    ident_o <= id;
    @(posedge clk_i);
    valid_o <= 1'b0;
    addr_o <= ~a;
    data_o <= ~d;
    ident_o <= ~id;
    be_o <= ~k[3:0];
  endtask : send
endmodule : irq_source_model

// ==== testbench/test_interrupt_request_decoder.sv ====
module test_interrupt_request_decoder;
  import irq_decode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] OK = 6'h2F;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, req_be_i;
  logic [31:0] wb_dat_i, wb_dat_o, req_addr_i, req_data_i, dec_addr_o, dec_data_o, rd;
  logic req_valid_i, req_write_i, req_internal_i, dec_valid_o, dec_remap_o;
  logic dec_sub_index_valid_o, dec_aliased_o, fault_valid_o;
  logic [15:0] req_requester_ident_i, dec_handle_o, dec_sub_index_o;
  logic [15:0] dec_requester_ident_o, fault_requester_ident_o;
  logic [7:0] fault_reason_o;
  int num_errors = 0;
  int checked = 0;

  interrupt_request_decoder uut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .req_valid_i, .req_write_i, .req_be_i, .req_internal_i,
    .req_addr_i, .req_data_i, .req_requester_ident_i, .dec_valid_o, .dec_remap_o,
    .dec_handle_o, .dec_sub_index_valid_o, .dec_sub_index_o, .dec_requester_ident_o,
    .dec_aliased_o, .dec_addr_o, .dec_data_o, .fault_valid_o, .fault_reason_o,
    .fault_requester_ident_o
  );

  irq_source_model src (
    .clk_i, .valid_o(req_valid_i), .write_o(req_write_i), .be_o(req_be_i),
    .internal_o(req_internal_i), .addr_o(req_addr_i), .data_o(req_data_i),
    .ident_o(req_requester_ident_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for the acknowledge
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // ev is {accept strobe, block strobe} expected at the falling edge after the taking edge
  task automatic req(input logic [31:0] a, input logic [31:0] d, input logic [15:0] id,
                     input logic [5:0] k, input logic [1:0] ev);
    src.send(a, d, id, k);
    @(negedge clk_i);
    chk(dec_valid_o, ev[1]);
    chk(fault_valid_o, ev[0]);
  endtask : req

  initial begin
    repeat (2000) @(posedge clk_i);
    num_errors++;
    conclude();
  end

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0, rd);
    chk(rd, 32'h1);
    wb(1'b0, BRIDGE_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    req(32'hFEE0_B4BF, 32'h0000_1234, 16'h0108, OK, 2'b10);
    chk(dec_remap_o, 1'b1);
    chk(dec_handle_o, 16'h85A5);
    chk(dec_sub_index_valid_o, 1'b1);
    chk(dec_sub_index_o, 16'h1234);
    chk(dec_requester_ident_o, 16'h0108);
    chk(dec_addr_o, 32'hFEE0_B4BF);
    chk(dec_data_o, 32'h0000_1234);
    req(32'hFEE0_B4B4, 32'hFFFF_5678, 16'h0109, OK, 2'b10);
    chk(dec_handle_o, 16'h85A5);
    chk(dec_sub_index_valid_o, 1'b0);
    chk(dec_sub_index_o, 16'h0);
    req(32'hFEE0_B4BA, 32'h0001_0000, 16'h0210, OK, 2'b01);
    chk(fault_reason_o, 8'h20);
    chk(fault_requester_ident_o, 16'h0210);
    chk(dec_handle_o, 16'h85A5);
    req(32'hFEE0_B4AC, 32'h0001_0000, 16'h0111, OK, 2'b10);
    chk(dec_remap_o, 1'b0);
    chk(dec_handle_o, 16'h0);
    req(32'hFEF0_0010, 32'h0, 16'h0112, OK, 2'b00);
    req(32'hFEE0_0010, 32'h0, 16'h0112, 6'h27, 2'b00);
    req(32'hFEE0_0010, 32'h0, 16'h0112, 6'h0F, 2'b00);
    req(32'hFEE0_0010, 32'h0, 16'h0112, 6'h3F, 2'b00);
    wb(1'b1, BRIDGE_OFS, 32'h0000_0105, rd);
    wb(1'b0, BRIDGE_OFS, 32'h0, rd);
    chk(rd, 32'h0000_0105);
    req(32'hFEE0_0010, 32'h0, 16'h0500, OK, 2'b10);
    chk(dec_aliased_o, 1'b1);
    req(32'hFEE0_0010, 32'h0, 16'h0501, OK, 2'b10);
    chk(dec_aliased_o, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h0, rd);
    req(32'hFEE0_B4BA, 32'h0001_0000, 16'h0300, OK, 2'b10);
    chk(dec_remap_o, 1'b0);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    chk(rd, 32'h0001_0006);
    wb(1'b1, FAULT_OFS, 32'h0, rd);
    wb(1'b0, FAULT_OFS, 32'h0, rd);
    chk(rd, 32'h0210_0020);
    wb(1'b1, STATUS_OFS, 32'h0, rd);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    // Clear and an accepted request taken at the same edge: the count keeps it
    fork
      wb(1'b1, STATUS_OFS, 32'h0, rd);
      src.send(32'hFEE0_0010, 32'h0, 16'h0113, OK);
    join
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    chk(rd, 32'h0000_0001);
    conclude();
  end
endmodule : test_interrupt_request_decoder
